// ===== shared/srq_pkg.sv
// Package for the secure-region and query host controller: register map,
// field positions, operation codes, pin timing and shared carrier types.
// Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
package srq_pkg;

  // ****************************************************************
  // Bus and flash widths
  // ****************************************************************
  localparam int unsigned AXI_AW      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned FLASH_AW    = 23;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_CMD      = 8'h04;
  localparam logic [7:0] REG_ADDR     = 8'h08;
  localparam logic [7:0] REG_WDATA    = 8'h0c;
  localparam logic [7:0] REG_STATUS   = 8'h10;
  localparam logic [7:0] REG_RDATA    = 8'h14;

  // Control fields
  localparam int unsigned CTRL_WORD   = 0;   // 1 = 16-bit word mode, 0 = 32-bit
  localparam int unsigned CTRL_RST    = 1;   // 1 = hold flash reset pin low
  localparam logic [1:0]  CTRL_RESET_VAL = 2'h0;

  // Status fields
  localparam int unsigned ST_BUSY     = 0;
  localparam int unsigned ST_ERR      = 1;
  localparam int unsigned ST_REGION   = 2;
  localparam int unsigned ST_QUERY    = 3;
  localparam int unsigned ST_PW_READY = 4;
  localparam int unsigned ST_RDY      = 5;

  // AXI responses
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_DECERR  = 2'h3;

  // ****************************************************************
  // Flash facts
  // ****************************************************************
  localparam logic [22:0] REGION_LAST_WORD  = 23'h00007f;
  localparam logic [22:0] REGION_LAST_DWORD = 23'h00003f;
  localparam logic [22:0] PW_LAST_WORD      = 23'h000003;  // Eight bytes as 16-bit words
  localparam logic [22:0] PW_LAST_DWORD     = 23'h000001;  // Eight bytes as 32-bit words
  localparam logic [3:0]  PW_FULL_WORD      = 4'hf;
  localparam logic [3:0]  PW_FULL_DWORD     = 4'h3;
  localparam logic [31:0] QUERY_CMD         = 32'h00000098;
  localparam logic [22:0] QUERY_ADDR_DWORD  = 23'h000055;
  localparam logic [22:0] QUERY_ADDR_WORD   = 23'h0000aa;

  // ****************************************************************
  // Operation codes written to the command register
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_WRITE  = 3'h0,
    OP_READ   = 3'h1,
    OP_QUERY  = 3'h2,
    OP_RESET  = 3'h3,
    OP_ENTER  = 3'h4,
    OP_EXIT   = 3'h5,
    OP_LOCKWR = 3'h6,
    OP_NONE   = 3'h7
  } srq_op_type;

  // ****************************************************************
  // Pin timing, in ns and derived clock counts
  // ****************************************************************
  localparam int unsigned CLK_NS      = 100;
  localparam int unsigned T_SETUP_NS  = 100;
  localparam int unsigned T_PULSE_NS  = 100;
  localparam int unsigned T_HOLD_NS   = 100;
  localparam int unsigned T_READ_NS   = 100;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] PULSE_CYC = 4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC  = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  // One more cycle: pins settle one edge after the state, then two sync flops
  localparam logic [3:0] READ_CYC  = 4'((T_READ_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES + 1);

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
  } srq_strobe_type;

  typedef struct packed {
    logic [22:0] addr;
    logic [31:0] data;
  } srq_step_type;

endpackage

// ===== rtl/srq_host_ctrl.sv
// Host controller for a parallel flash with a lockable secure region and a
// query table. Software drives it over AXI4-Lite; it drives the flash strobes.
// Assumes flash inputs (data, ready) are asynchronous and get two flops first.
//
// Notes on behaviour
// [RQ1] Region spans lowest 128 words or 64 dwords
// [RQ2] Factory-locked region refuses all program and erase
// [RQ3] Customer region: unlimited reads, program once
// [RQ4] No accelerated or bypass programming in region
// [RQ5] Protect region: enter sequence, then protect algorithm
// [RQ6] Exit region before touching the rest
// [RQ7] Locked region never unlocks or changes
// [RQ8] Protection bit set: region programs ignored
// [RQ9] Password is first eight bytes, hidden after lock
// [RQ10] Protection bit blocks every region location
// [RQ11] Write password before any lock bit
// [RQ12] Setup order one: password, lock, data, protect
// [RQ13] Setup order two: all data, lock, protect
// [RQ14] Low supply refuses writes, returns to read
// [RQ15] Write only with select, strobe low, output high
// [RQ16] Power-up strobes low accept no command
// [RQ17] Query command 98h enters query mode
// [RQ18] Reset command leaves query mode
// [RQ19] No query entry while program or erase runs
// [RQ20] Query accepted from identifier mode too
// [RQ21] Query string, command set, table pointer
// [RQ22] Supply limits and timeout exponents follow
// [RQ23] Region reads replace boot area until exit; the code also clears in_region_q on OP_RESET
// [RQ24] Query data on low byte; writes ignored
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ns
module srq_host_ctrl
  import srq_pkg::*;
#(
  parameter logic [22:0] UNLOCK_ADDR1 = 23'h000555,
  parameter logic [22:0] UNLOCK_ADDR2 = 23'h0002aa,
  parameter logic [31:0] UNLOCK_DATA1 = 32'h000000aa,
  parameter logic [31:0] UNLOCK_DATA2 = 32'h00000055,
  parameter logic [31:0] ENTER_DATA   = 32'h00000088,
  parameter logic [31:0] EXIT_DATA    = 32'h00000090,
  parameter logic [31:0] EXIT_DATA2   = 32'h00000000,
  parameter logic [31:0] RESET_DATA   = 32'h000000f0
) (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write address, data and response
  input  wire logic [AXI_AW-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read
  input  wire logic [AXI_AW-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Flash control pins
  output srq_strobe_type            flash_strobe,
  output logic [FLASH_AW-1:0]       flash_addr,
  output logic                      flash_word_mode,
  output logic                      flash_reset_n,
  // Flash data bus, split three ways
  input  wire logic [DATA_W-1:0]    flash_dq_in,
  output logic [DATA_W-1:0]         flash_dq_out,
  output logic                      flash_dq_oe_n,
  // Flash ready/busy
  input  wire logic                 flash_ready
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_WAIT  = 3'h1,
    ST_SETUP = 3'h2,
    ST_PULSE = 3'h3,
    ST_HOLD  = 3'h4,
    ST_RDWT  = 3'h5
  } srq_state_type;

  srq_state_type        state_q;
  srq_op_type           op_q;
  logic [1:0]           ctrl_q;
  logic [22:0]          addr_q;
  logic [31:0]          wdata_q;
  logic [31:0]          rdata_q;
  logic                 err_q;
  logic                 in_region_q;
  logic                 in_query_q;
  logic [3:0]           pw_mask_q;
  logic [3:0]           cnt_q;
  logic [2:0]           step_q;
  logic [2:0]           last_step;
  logic [AXI_AW-1:0]    awaddr_q;
  logic [31:0]          wbuf_q;
  logic [3:0]           wstrb_q;
  logic                 aw_held_q;
  logic                 w_held_q;
  logic [1:0]           rdy_sync_q;
  logic [31:0]          dq_meta_q;
  logic [31:0]          dq_sync_q;
  logic                 wr_fire;
  logic                 cmd_wr;
  logic                 refuse;
  logic                 start;
  logic [22:0]          region_last;
  logic [22:0]          pw_last;
  logic [3:0]           pw_full;
  logic                 pw_ready;
  srq_op_type           new_op;
  srq_step_type         step;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Pins are asynchronous to aclk; only the second stage is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdy_sync_q <= 2'h0;
      dq_meta_q  <= 32'h00000000;
      dq_sync_q  <= 32'h00000000;
    end else begin
      rdy_sync_q <= {rdy_sync_q[0], flash_ready};
      dq_meta_q  <= flash_dq_in;
      dq_sync_q  <= dq_meta_q;
    end
  end

  // ****************************************************************
  // Mode-dependent limits
  // ****************************************************************
  assign region_last = ctrl_q[CTRL_WORD] ? REGION_LAST_WORD : REGION_LAST_DWORD; // [RQ1]
  assign pw_last     = ctrl_q[CTRL_WORD] ? PW_LAST_WORD : PW_LAST_DWORD;         // [RQ9]
  assign pw_full     = ctrl_q[CTRL_WORD] ? PW_FULL_WORD : PW_FULL_DWORD;
  assign pw_ready    = (pw_mask_q & pw_full) == pw_full;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
  assign cmd_wr        = wr_fire && (awaddr_q == REG_CMD);

  // Address and data are held separately, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wbuf_q       <= 32'h00000000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wbuf_q   <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q == REG_CTRL || awaddr_q == REG_CMD ||
                         awaddr_q == REG_ADDR || awaddr_q == REG_WDATA ||
                         awaddr_q == REG_STATUS || awaddr_q == REG_RDATA)
                        ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
      end
    end
  end

  // Byte-lane merge for the software registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Control, address and write-data registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q  <= CTRL_RESET_VAL;
      addr_q  <= 23'h000000;
      wdata_q <= 32'h00000000;
    end else if (wr_fire) begin
      if (awaddr_q == REG_CTRL && state_q == ST_IDLE) begin
        ctrl_q <= 2'(merge({30'h00000000, ctrl_q}, wbuf_q, wstrb_q));
      end
      if (awaddr_q == REG_ADDR) begin
        addr_q <= 23'(merge({9'h000, addr_q}, wbuf_q, wstrb_q));
      end
      if (awaddr_q == REG_WDATA) begin
        wdata_q <= merge(wdata_q, wbuf_q, wstrb_q);
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;

  // One-cycle read answer; unmapped offsets give DECERR and zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case (s_axi_araddr)
        REG_CTRL:   s_axi_rdata <= {30'h00000000, ctrl_q};
        REG_CMD:    s_axi_rdata <= {29'h00000000, op_q};
        REG_ADDR:   s_axi_rdata <= {9'h000, addr_q};
        REG_WDATA:  s_axi_rdata <= wdata_q;
        REG_STATUS: s_axi_rdata <= {26'h0000000, rdy_sync_q[1], pw_ready, in_query_q,
                                    in_region_q, err_q, (state_q != ST_IDLE)};
        REG_RDATA:  s_axi_rdata <= rdata_q;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_DECERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Command check
  // ****************************************************************
  assign new_op = srq_op_type'(wbuf_q[2:0]);

  // Refuse what would break the device's protocol instead of sending it
  always_comb begin
    refuse = 1'b0;
    if (state_q != ST_IDLE || new_op == OP_NONE) begin
      refuse = 1'b1;
    end else if (in_query_q && new_op != OP_RESET && new_op != OP_READ &&
                 new_op != OP_QUERY) begin
      refuse = 1'b1;                                             // [RQ18] [RQ24]
    end else if (in_region_q && (new_op == OP_WRITE || new_op == OP_READ) &&
                 addr_q > region_last) begin
      refuse = 1'b1;                                             // [RQ6] [RQ23]
    end else if (new_op == OP_LOCKWR && (!in_region_q || !pw_ready)) begin
      refuse = 1'b1;                                             // [RQ5] [RQ11]
    end
  end
  assign start = cmd_wr && !refuse;

  // ****************************************************************
  // Bus cycle steps per operation
  // ****************************************************************
  always_comb begin
    last_step = 3'h0;
    step      = '{addr: addr_q, data: wdata_q};
    unique case (op_q)
      OP_QUERY: begin
        step.addr = ctrl_q[CTRL_WORD] ? QUERY_ADDR_WORD : QUERY_ADDR_DWORD;  // [RQ17]
        step.data = QUERY_CMD;                                               // [RQ20]
      end
      OP_RESET: step.data = RESET_DATA;                                      // [RQ18]
      OP_ENTER, OP_EXIT: begin
        last_step = (op_q == OP_ENTER) ? 3'h2 : 3'h3;                        // [RQ5]
        unique case (step_q)
          3'h0:    step = '{addr: UNLOCK_ADDR1, data: UNLOCK_DATA1};
          3'h1:    step = '{addr: UNLOCK_ADDR2, data: UNLOCK_DATA2};
          3'h2:    step = '{addr: UNLOCK_ADDR1,
                            data: (op_q == OP_ENTER) ? ENTER_DATA : EXIT_DATA};
          default: step = '{addr: addr_q, data: EXIT_DATA2};
        endcase
      end
      default: ;
    endcase
  end

  // ****************************************************************
  // Pin sequencer
  // ****************************************************************
  // Each write step: setup with select low and write strobe high, write strobe pulse, hold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      op_q    <= OP_NONE;
      cnt_q   <= 4'h0;
      step_q  <= 3'h0;
      rdata_q <= 32'h00000000;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            op_q    <= new_op;
            step_q  <= 3'h0;
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Busy flash gets nothing, so no query lands mid-algorithm
          if (rdy_sync_q[1] && ctrl_q[CTRL_RST] == 1'b0) begin               // [RQ19]
            cnt_q   <= (op_q == OP_READ) ? READ_CYC : SETUP_CYC;
            state_q <= (op_q == OP_READ) ? ST_RDWT : ST_SETUP;
          end
        end
        ST_SETUP: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            cnt_q   <= PULSE_CYC;
            state_q <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            cnt_q   <= HOLD_CYC;
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            if (step_q == last_step) begin
              state_q <= ST_IDLE;
            end else begin
              step_q  <= step_q + 3'h1;
              cnt_q   <= SETUP_CYC;
              state_q <= ST_SETUP;
            end
          end
        end
        ST_RDWT: begin
          // Two extra cycles cover the data synchroniser
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            rdata_q <= in_query_q ? {24'h000000, dq_sync_q[7:0]} : dq_sync_q;  // [RQ24]
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Mode tracking and error flag
  // ****************************************************************
  // Modes change when the last cycle of their sequence completes, and clear while the reset bit is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_region_q <= 1'b0;
      in_query_q  <= 1'b0;
      pw_mask_q   <= 4'h0;
    end else if (ctrl_q[CTRL_RST]) begin
      in_region_q <= 1'b0;                                                    // [RQ23]
      in_query_q  <= 1'b0;
    end else if (state_q == ST_HOLD && cnt_q == 4'h1 && step_q == last_step) begin
      unique case (op_q)
        OP_ENTER: in_region_q <= 1'b1;                                        // [RQ23]
        OP_EXIT:  in_region_q <= 1'b0;                                        // [RQ6]
        OP_QUERY: in_query_q  <= 1'b1;                                        // [RQ17]
        OP_RESET: begin
          in_query_q  <= 1'b0;                                                // [RQ18]
          in_region_q <= 1'b0;                                                // [RQ13]
        end
        OP_WRITE: begin
          if (in_region_q && addr_q <= pw_last) begin
            pw_mask_q[addr_q[1:0]] <= 1'b1;                                   // [RQ12]
          end
        end
        default: ;
      endcase
    end
  end

  // Sticky error; a refusal in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_q <= 1'b0;
    end else if (cmd_wr && refuse) begin
      err_q <= 1'b1;
    end else if (start) begin
      err_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // Output enable stays high whenever write strobe is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_strobe    <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
      flash_addr      <= 23'h000000;
      flash_dq_out    <= 32'h00000000;
      flash_dq_oe_n   <= 1'b1;
      flash_word_mode <= 1'b0;
      flash_reset_n   <= 1'b0;
    end else begin
      flash_word_mode <= ctrl_q[CTRL_WORD];
      flash_reset_n   <= !ctrl_q[CTRL_RST];
      flash_strobe.ce_n <= !(state_q == ST_SETUP || state_q == ST_PULSE ||
                             state_q == ST_HOLD || state_q == ST_RDWT);
      flash_strobe.we_n <= !(state_q == ST_PULSE);                            // [RQ15]
      flash_strobe.oe_n <= !(state_q == ST_RDWT);                             // [RQ15]
      flash_dq_oe_n     <= !(state_q == ST_SETUP || state_q == ST_PULSE ||
                             state_q == ST_HOLD);
      if (state_q == ST_SETUP || state_q == ST_RDWT) begin
        flash_addr   <= step.addr;
        flash_dq_out <= step.data;
      end
    end
  end

endmodule

// ===== test/srq_flash_model.sv
// Behavioural flash: query mode and its table, commands on write strobe rise.
// Assumes the bench resolves the shared data bus into dq.
`timescale 1ns/1ns
module srq_flash_model
  import srq_pkg::*;
(
  // Pins
  input  wire srq_strobe_type st,
  input  wire logic [22:0]    a,
  input  wire logic [31:0]    dq,
  input  wire logic           wm,
  input  wire logic           rst_n,
  output logic [31:0]         q,
  output logic                rdy
);
  logic        qm;
  logic        we;
  logic [31:0] v;
  logic [7:0]  w;
  assign rdy = 1'b1;  // Never busy, so query entry is never blocked
  assign we  = st.we_n;
  assign w   = wm ? a[8:1] : a[7:0];  // Word addresses are doubled
  // Reset leaves query mode; commands need select low, output high
  always @(posedge we or negedge rst_n) begin
    if (!rst_n) begin
      qm <= 1'b0;
    end else if (!st.ce_n && st.oe_n) begin
      if (dq[7:0] == 8'h98 && a == (wm ? 23'h0000aa : 23'h000055)) begin
        qm <= 1'b1;
      end else if (dq[7:0] == 8'hf0) begin
        qm <= 1'b0;  // Other writes ignored in query mode
      end
    end
  end
  // Low-byte table; a released bus shows the inverse, so stale data fails
  always_comb begin
    v = {9'h0, a};
    if (qm) begin
      case (w)
        8'h10: v = 32'h51;
        8'h11: v = 32'h52;
        8'h12: v = 32'h59;
        8'h13: v = 32'h02;
        8'h15: v = 32'h40;
        8'h1f: v = 32'h04;
        8'h21: v = 32'h0a;
        8'h23: v = 32'h05;
        8'h25: v = 32'h04;
        default: v = 32'h0;
      endcase
    end
    q = (!st.ce_n && !st.oe_n) ? v : ~v;
  end
endmodule

// ===== test/srq_host_ctrl_chk.sv
// Checks flash strobe sequencing at the controller's pins.
// Assumes one clock domain; bound to every controller instance.
`timescale 1ns/1ns
module srq_host_ctrl_chk
  import srq_pkg::*;
(
  // Watched ports
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire srq_strobe_type      flash_strobe,
  input wire logic [FLASH_AW-1:0] flash_addr,
  input wire logic [DATA_W-1:0]   flash_dq_out,
  input wire logic                flash_dq_oe_n
);
  // ****************************************************************
  // Strobe rules
  // ****************************************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_gate: assert property (!flash_strobe.we_n |-> flash_strobe.oe_n && !flash_strobe.ce_n)
    else $error("bad write gate");
  a_data_driven: assert property (!flash_strobe.we_n |-> !flash_dq_oe_n)
    else $error("data undriven");
  a_setup_first: assert property ($fell(flash_strobe.we_n) |-> $past(!flash_strobe.ce_n))
    else $error("no setup");
  a_pulse_once: assert property ($fell(flash_strobe.we_n) |=> flash_strobe.we_n)
    else $error("long pulse");
  a_hold_after: assert property ($rose(flash_strobe.we_n) |-> !flash_strobe.ce_n && !flash_dq_oe_n)
    else $error("no hold");
  a_stable_pins: assert property (!flash_strobe.we_n |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("pins moved");
  a_read_gate: assert property (!flash_strobe.oe_n |-> !flash_strobe.ce_n && flash_dq_oe_n)
    else $error("bus contention");
  a_read_len: assert property ($fell(flash_strobe.oe_n) |-> (!flash_strobe.oe_n)[*3])
    else $error("short read");
  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> flash_strobe == 3'h7 && flash_dq_oe_n)
    else $error("strobes on");
endmodule
bind srq_host_ctrl srq_host_ctrl_chk u_chk (.aclk, .aresetn, .flash_strobe, .flash_addr,
  .flash_dq_out, .flash_dq_oe_n);

// ===== test/tb_top.sv
// Self-checking bench: AXI4-Lite master tasks and a behavioural flash.
// Assumes the package's register map and op codes.
`timescale 1ns/1ns
module tb_top
  import srq_pkg::*;
;
  logic           aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, brd = 1'b0;
  logic           arv = 1'b0, rrd = 1'b0;
  logic [7:0]     awa = 8'h00, ara = 8'h00;
  logic [31:0]    wd = 32'h0;
  logic [31:0]    rdat, st, dq, mq, fdo, r;
  logic           awr, wr_rdy, bv, arr, rv, oe_n, wm, frn, rdy;
  logic [1:0]     bresp, rresp;
  logic [22:0]    fa;
  srq_strobe_type stb;
  int             mismatches = 0;
  int             n_tests = 0;

  always #50 aclk = ~aclk;
  assign dq = oe_n ? mq : fdo;  // Whoever enables drives the shared bus

  srq_host_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd),
    .flash_strobe(stb), .flash_addr(fa), .flash_word_mode(wm), .flash_reset_n(frn),
    .flash_dq_in(dq), .flash_dq_out(fdo), .flash_dq_oe_n(oe_n), .flash_ready(rdy));
  srq_flash_model u_mdl (.st(stb), .a(fa), .dq(dq), .wm(wm), .rst_n(frn), .q(mq), .rdy(rdy));

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    brd <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (!bv);
    brd <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    d = rdat;
    rrd <= 1'b0;
  endtask
  // Issue an op and poll until busy drops; a hang is left to the watchdog
  task automatic op(input srq_op_type c);
    wr(REG_CMD, 32'(c));
    do rd(REG_STATUS, st);
    while (st[ST_BUSY] !== 1'b0);
  endtask
  task automatic cs(input logic [2:0] e);
    chk(32'(st[3:1]), 32'(e));
  endtask
  task automatic summarize;
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    chk(32'(stb), 32'h7);
    rd(REG_CMD, r);
    chk(r, 32'h7);
    rd(8'h20, r);
    chk(32'(rresp), 32'(RESP_DECERR));
    wr(8'h20, 32'h1);
    chk(32'(bresp), 32'(RESP_DECERR));
  endtask
  task automatic t_query(input logic m);
    logic [15:0] tv [11] = '{16'h1051, 16'h1152, 16'h1259, 16'h1302, 16'h1400, 16'h1540,
                             16'h1d00, 16'h1f04, 16'h210a, 16'h2305, 16'h2504};
    wr(REG_CTRL, {31'h0, m});
    op(OP_QUERY);
    cs(3'h4);
    for (int i = 0; i < 11; i++) begin
      wr(REG_ADDR, 32'(tv[i][15:8]) << m);
      op(OP_READ);
      rd(REG_RDATA, r);
      chk(r, 32'(tv[i][7:0]));
    end
    op(OP_WRITE);
    cs(3'h5);
    op(OP_RESET);
    cs(3'h0);
  endtask
  task automatic t_region;
    wr(REG_CTRL, 32'h1);
    op(OP_ENTER);
    cs(3'h2);
    wr(REG_ADDR, 32'h80);
    op(OP_WRITE);
    cs(3'h3);
    wr(REG_ADDR, 32'h7f);
    op(OP_WRITE);
    cs(3'h2);
    op(OP_LOCKWR);
    cs(3'h3);
    for (int i = 0; i < 4; i++) begin
      wr(REG_ADDR, 32'(i));
      op(OP_WRITE);
    end
    op(OP_LOCKWR);
    chk(32'(st[4:1]), 32'ha);
    op(OP_EXIT);
    cs(3'h0);
  endtask

  // Main sequence; watchdog set well above the run
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_query(1'b1);
    t_query(1'b0);
    t_region;
    summarize;
  end
  initial begin
    #3000000;
    mismatches++;
    summarize;
  end
endmodule
